// ===== hw/core_cfg.svh
// Fixed sizes, instruction field positions, reset values and stack/page limits
// of the fetch/execute core. Definitions only; included by the core.
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

`define PC_W             11
`define PM_W             15
`define DM_AW            7
`define PAGE_LSB         8
`define OP_MSB           14
`define OP_LSB           11
`define FN_MSB           10
`define FN_LSB           7
`define MA_MSB           6
`define LEVEL_W          3
`define STACK_FULL       3'h4
`define PHASE_RESET      4'h1
`define RESET_VECTOR     11'h000
`define PC_ONE           11'h001
`define PC_LOW_BYTE_ADDR 7'h06
`define LAST_PAGE        3'h7
`define ACC_RESET        8'h00
`define STATUS_RESET     4'h0

`endif

// ===== hw/core_pkg.sv
// Types shared by the core and its ALU: phases, opcodes, ALU functions,
// status flags and the ALU result bundle.
package core_pkg;

   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} phase_t;

   // Major opcode in the top four bits of the instruction word
   typedef enum logic [3:0] {
      OP_NOP        = 4'h0,
      OP_ALU_A      = 4'h1,
      OP_ALU_M      = 4'h2,
      OP_SKZ        = 4'h3,
      OP_JUMP       = 4'h4,
      OP_CALL       = 4'h5,
      OP_RETURN_SUB = 4'h6,
      OP_RETURN_INT = 4'h7,
      OP_TBL_CUR    = 4'h8,
      OP_TBL_LAST   = 4'h9
   } op_t;

   typedef enum logic [3:0] {
      FN_ADD = 4'h0, FN_ADC = 4'h1, FN_SUB = 4'h2, FN_SBC = 4'h3,
      FN_AND = 4'h4, FN_OR  = 4'h5, FN_XOR = 4'h6, FN_CPL = 4'h7,
      FN_RR  = 4'h8, FN_RRC = 4'h9, FN_RL  = 4'ha, FN_RLC = 4'hb,
      FN_INC = 4'hc, FN_DEC = 4'hd, FN_DECIMAL_ADJUST = 4'he, FN_MOVE = 4'hf
   } alu_fn_t;

   typedef struct packed {
      logic ov;
      logic z;
      logic ac;
      logic c;
   } status_t;

   typedef struct packed {
      logic [7:0] result;
      status_t    flags;
      status_t    upd;
   } alu_res_t;

endpackage

// ===== hw/alu8.sv
// Eight-bit ALU: shared adder, logic, rotates, decimal adjust, flag masks.
// Purely combinational; the core decides where result and flags land.
`timescale 1ns/100ps
module alu8 (
   input  wire logic [7:0]         a,
   input  wire logic [7:0]         b,
   input  wire core_pkg::status_t  st_in,
   input  wire core_pkg::alu_fn_t  fn,
   output core_pkg::alu_res_t      res
);
   logic [7:0] x;
   logic [7:0] y;
   logic       c;
   logic [8:0] sum;
   logic [4:0] half;
   logic [8:0] adj;

   // Adder operands; subtract adds the complement so carry means no borrow
   always_comb begin
      x = a;
      y = b;
      c = 1'b0;
      case (fn)
         core_pkg::FN_ADC: c = st_in.c;
         core_pkg::FN_SUB: begin
            y = ~b;
            c = 1'b1;
         end
         core_pkg::FN_SBC: begin
            y = ~b;
            c = st_in.c;
         end
         core_pkg::FN_INC: begin
            x = b;
            y = 8'h00;
            c = 1'b1;
         end
         core_pkg::FN_DEC: begin
            x = b;
            y = 8'hff;
         end
         default: c = 1'b0;
      endcase
      sum  = {1'b0, x} + {1'b0, y} + {8'h00, c};
      half = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c};
   end

   // Decimal adjust of the accumulator after a packed BCD add
   always_comb begin
      adj = {1'b0, a};
      if (a[3:0] > 4'h9 || st_in.ac) begin
         adj = adj + 9'h006;
      end
      if (adj[7:4] > 4'h9 || st_in.c || adj[8]) begin
         adj = adj + 9'h060;
      end
   end

   // Result and the mask of flags each function may change
   always_comb begin
      res = '0;
      case (fn)
         core_pkg::FN_ADD, core_pkg::FN_ADC, core_pkg::FN_SUB, core_pkg::FN_SBC: begin
            res.result   = sum[7:0];
            res.flags.c  = sum[8];
            res.flags.ac = half[4];
            res.flags.ov = (x[7] == y[7]) && (sum[7] != x[7]);
            res.upd      = core_pkg::status_t'(4'hf);
         end
         core_pkg::FN_INC, core_pkg::FN_DEC: begin
            res.result = sum[7:0];
            res.upd.z  = 1'b1;
         end
         core_pkg::FN_AND: begin
            res.result = a & b;
            res.upd.z  = 1'b1;
         end
         core_pkg::FN_OR: begin
            res.result = a | b;
            res.upd.z  = 1'b1;
         end
         core_pkg::FN_XOR: begin
            res.result = a ^ b;
            res.upd.z  = 1'b1;
         end
         core_pkg::FN_CPL: begin
            res.result = ~b;
            res.upd.z  = 1'b1;
         end
         core_pkg::FN_RR: res.result = {b[0], b[7:1]};
         core_pkg::FN_RL: res.result = {b[6:0], b[7]};
         core_pkg::FN_RRC: begin
            res.result  = {st_in.c, b[7:1]};
            res.flags.c = b[0];
            res.upd.c   = 1'b1;
         end
         core_pkg::FN_RLC: begin
            res.result  = {b[6:0], st_in.c};
            res.flags.c = b[7];
            res.upd.c   = 1'b1;
         end
         core_pkg::FN_DECIMAL_ADJUST: begin
            res.result  = adj[7:0];
            res.flags.c = adj[8] | st_in.c;
            res.upd.c   = 1'b1;
         end
         default: res.result = b;
      endcase
      res.flags.z = (res.result == 8'h00);
   end

endmodule

// ===== hw/fetch_exec_core.sv
// Instruction sequencing core: phase ring, overlapped fetch/execute,
// program counter, hidden return stack, ALU control and table reads.
// Assumes program memory returns the word at PM_ADDR by the end of phase
// four and data memory read data is valid from phase two onward.
`timescale 1ns/100ps
`include "core_cfg.svh"
module fetch_exec_core (
   input  wire logic               CORE_CLK,
   input  wire logic               RST_N,
   output logic [`PC_W-1:0]        PM_ADDR,
   input  wire logic [`PM_W-1:0]   PM_DATA,
   output logic [`DM_AW-1:0]       DM_ADDR,
   input  wire logic [7:0]         DM_RDATA,
   output logic [7:0]              DM_WDATA,
   output logic                    DM_WE,
   input  wire logic [7:0]         TABLE_POINTER,
   output logic [7:0]              TABLE_HIGH,
   input  wire logic               INT_EVENT,
   input  wire logic               INT_ENABLE,
   input  wire logic [`PC_W-1:0]   INT_VECTOR,
   output logic                    INT_ACK,
   output logic                    INT_RETURN,
   output logic [3:0]              INSTRUCTION_PHASE_CLOCKS,
   output core_pkg::status_t       STATUS,
   output logic [7:0]              ACC
);

   // -------------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------------
   function automatic logic is_mem_dest(input core_pkg::op_t o);
      is_mem_dest = (o == core_pkg::OP_ALU_M) || (o == core_pkg::OP_SKZ);
   endfunction

   function automatic logic is_alu(input core_pkg::op_t o);
      is_alu = (o == core_pkg::OP_ALU_A) || (o == core_pkg::OP_ALU_M);
   endfunction

   function automatic logic is_return(input core_pkg::op_t o);
      is_return = (o == core_pkg::OP_RETURN_SUB) || (o == core_pkg::OP_RETURN_INT);
   endfunction

   function automatic logic is_tbl(input core_pkg::op_t o);
      is_tbl = (o == core_pkg::OP_TBL_CUR) || (o == core_pkg::OP_TBL_LAST);
   endfunction

   core_pkg::phase_t    ph;
   logic [`PC_W-1:0]    pc;
   logic [`PC_W-1:0]    ir_pc;
   logic [`PM_W-1:0]    ir;
   logic                ir_valid;
   logic                tbl_busy;
   logic [`DM_AW-1:0]   tbl_dest;
   logic [`PC_W-1:0]    stack [0:3];
   logic [1:0]          top;
   logic [`LEVEL_W-1:0] return_stack_level_pointer;
   logic                int_pend;
   core_pkg::op_t       op;
   core_pkg::alu_fn_t   fn;
   logic [`DM_AW-1:0]   maddr;
   logic [7:0]          operand;
   logic [7:0]          alu_b;
   core_pkg::alu_res_t  res;
   logic                t4;
   logic                commit;
   logic                full;
   logic                jump;
   logic                call;
   logic                do_return;
   logic                low_byte_write;
   logic                skip_hit;
   logic                tbl_go;
   logic                flow;
   logic                int_take;
   logic                flush;
   logic                push;
   logic [`PC_W-1:0]    pop_pc;
   logic [`PC_W-1:0]    next_pc;

   // -------------------------------------------------------------------
   // Phase generation
   // -------------------------------------------------------------------
   // Phase state steps once per clock; four clocks make one cycle
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ph <= core_pkg::PH_ONE;
      end else begin
         unique case (ph)
            core_pkg::PH_ONE:   ph <= core_pkg::PH_TWO;
            core_pkg::PH_TWO:   ph <= core_pkg::PH_THREE;
            core_pkg::PH_THREE: ph <= core_pkg::PH_FOUR;
            core_pkg::PH_FOUR:  ph <= core_pkg::PH_ONE;
         endcase
      end
   end

   // Non-overlapping phase strobes as a rotating one-hot register
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         INSTRUCTION_PHASE_CLOCKS <= `PHASE_RESET;
      end else begin
         INSTRUCTION_PHASE_CLOCKS <= {INSTRUCTION_PHASE_CLOCKS[2:0], INSTRUCTION_PHASE_CLOCKS[3]};
      end
   end

   assign t4 = (ph == core_pkg::PH_FOUR);

   // -------------------------------------------------------------------
   // Decode and execute
   // -------------------------------------------------------------------
   // Fields are decoded from phase one; effects land at the end of phase four
   assign op      = core_pkg::op_t'(ir[`OP_MSB:`OP_LSB]);
   assign fn      = core_pkg::alu_fn_t'(ir[`FN_MSB:`FN_LSB]);
   assign maddr   = ir[`MA_MSB:0];
   assign operand = (maddr == `PC_LOW_BYTE_ADDR) ? ir_pc[7:0] : DM_RDATA;
   // A move towards memory stores the accumulator instead of the operand
   assign alu_b   = (op == core_pkg::OP_ALU_M && fn == core_pkg::FN_MOVE) ? ACC : operand;
   assign commit  = t4 && ir_valid && !tbl_busy;

   alu8 u_alu (
      .a     (ACC),
      .b     (alu_b),
      .st_in (STATUS),
      .fn    (fn),
      .res   (res)
   );

   assign full           = (return_stack_level_pointer == `STACK_FULL);
   assign jump           = commit && (op == core_pkg::OP_JUMP || op == core_pkg::OP_CALL);
   assign call           = commit && (op == core_pkg::OP_CALL);
   assign do_return      = commit && is_return(op);
   assign low_byte_write = commit && is_mem_dest(op) && (maddr == `PC_LOW_BYTE_ADDR);
   assign skip_hit       = commit && (op == core_pkg::OP_SKZ) && (res.result == 8'h00);
   assign tbl_go         = commit && is_tbl(op);
   assign flow           = jump || do_return || low_byte_write || skip_hit || tbl_go;
   // Interrupts enter only between plain instructions and never overfill the stack
   assign int_take       = t4 && int_pend && INT_ENABLE && !full && !tbl_busy && !flow;
   assign flush          = int_take || jump || do_return || low_byte_write || skip_hit;
   assign push           = int_take || call;
   assign pop_pc         = stack[top - 2'h1];

   // Next fetch address; the table cycle holds the counter still
   always_comb begin
      if (int_take) begin
         next_pc = INT_VECTOR;
      end else if (jump) begin
         next_pc = ir[`PC_W-1:0];
      end else if (do_return) begin
         next_pc = pop_pc;
      end else if (low_byte_write) begin
         next_pc = {ir_pc[`PC_W-1:`PAGE_LSB], res.result};
      end else if (tbl_busy) begin
         next_pc = pc;
      end else begin
         next_pc = pc + `PC_ONE;
      end
   end

   // Counter moves on the edge that opens phase one
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         pc <= `RESET_VECTOR;
      end else if (t4) begin
         pc <= next_pc;
      end
   end

   // Fetch address: the counter, or the table location for one cycle
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         PM_ADDR <= `RESET_VECTOR;
      end else if (t4) begin
         if (tbl_go) begin
            PM_ADDR <= {(op == core_pkg::OP_TBL_LAST) ? `LAST_PAGE : ir_pc[`PC_W-1:`PAGE_LSB],
                        TABLE_POINTER};
         end else begin
            PM_ADDR <= next_pc;
         end
      end
   end

   // Prefetched word becomes the next instruction; branches turn it into a bubble
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ir       <= 15'h0000;
         ir_pc    <= `RESET_VECTOR;
         ir_valid <= 1'b0;
      end else if (t4 && !tbl_busy) begin
         ir       <= PM_DATA;
         ir_pc    <= pc;
         ir_valid <= !flush;
      end
   end

   // -------------------------------------------------------------------
   // Table read
   // -------------------------------------------------------------------
   // Second cycle borrows the fetch slot, so the word already in ir waits
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         tbl_busy   <= 1'b0;
         tbl_dest   <= 7'h00;
         TABLE_HIGH <= 8'h00;
      end else if (t4) begin
         tbl_busy <= tbl_go;
         if (tbl_go) begin
            tbl_dest <= maddr;
         end
         if (tbl_busy) begin
            TABLE_HIGH <= {1'b0, PM_DATA[`PM_W-1:8]};
         end
      end
   end

   // -------------------------------------------------------------------
   // Accumulator, status and data memory write
   // -------------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ACC    <= `ACC_RESET;
         STATUS <= core_pkg::status_t'(`STATUS_RESET);
      end else if (commit && is_alu(op)) begin
         if (op == core_pkg::OP_ALU_A) begin
            ACC <= res.result;
         end
         STATUS <= core_pkg::status_t'((STATUS & ~res.upd) | (res.flags & res.upd));
      end
   end

   // Writes land in the next phase one, well before the next read in phase four
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         DM_WE    <= 1'b0;
         DM_ADDR  <= 7'h00;
         DM_WDATA <= 8'h00;
      end else if (t4) begin
         DM_WE    <= (commit && is_mem_dest(op) && !low_byte_write) || tbl_busy;
         DM_ADDR  <= tbl_busy ? tbl_dest : maddr;
         DM_WDATA <= tbl_busy ? PM_DATA[7:0] : res.result;
      end else if (ph == core_pkg::PH_ONE) begin
         DM_WE   <= 1'b0;
         DM_ADDR <= ir[`MA_MSB:0];
      end
   end

   // -------------------------------------------------------------------
   // Return stack and interrupt entry
   // -------------------------------------------------------------------
   // Storage is private; a call on a full stack wraps onto the oldest entry
   always_ff @(posedge CORE_CLK) begin
      if (push) begin
         stack[top] <= pc;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         top                        <= 2'h0;
         return_stack_level_pointer <= 3'h0;
      end else if (push) begin
         top <= top + 2'h1;
         if (!full) begin
            return_stack_level_pointer <= return_stack_level_pointer + 3'h1;
         end
      end else if (do_return) begin
         top <= top - 2'h1;
         if (return_stack_level_pointer != 3'h0) begin
            return_stack_level_pointer <= return_stack_level_pointer - 3'h1;
         end
      end
   end

   // A new event in the acknowledge cycle keeps the request pending
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         int_pend   <= 1'b0;
         INT_ACK    <= 1'b0;
         INT_RETURN <= 1'b0;
      end else begin
         int_pend   <= INT_EVENT || (int_pend && !int_take);
         INT_ACK    <= int_take;
         INT_RETURN <= commit && (op == core_pkg::OP_RETURN_INT);
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   AST_PHASE_RING: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      INSTRUCTION_PHASE_CLOCKS[0] && (ph == core_pkg::PH_ONE)
      |=> INSTRUCTION_PHASE_CLOCKS == 4'h2 ##1 INSTRUCTION_PHASE_CLOCKS == 4'h4
          ##1 (INSTRUCTION_PHASE_CLOCKS == 4'h8 && t4) ##1 INSTRUCTION_PHASE_CLOCKS == 4'h1)
      else $error("phase ring out of step");

   AST_PC_HOLD: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      !t4 |=> $stable(pc) && $stable(PM_ADDR))
      else $error("program counter moved outside phase one entry");

   AST_PC_STEP: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      t4 && !flow && !int_take && !tbl_busy |=> pc == $past(pc) + `PC_ONE)
      else $error("program counter did not step by one");

   AST_JUMP_TWO: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      jump |=> (!ir_valid && pc == $past(ir[`PC_W-1:0])) ##4 (ir_pc == $past(ir[`PC_W-1:0], 5)))
      else $error("branch did not flush and fetch target");

   AST_INT_ENTRY: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      int_take |=> pc == $past(INT_VECTOR) && INT_ACK && !ir_valid)
      else $error("interrupt entry did not load vector");

   AST_SKIP_DUMMY: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      skip_hit |=> !ir_valid && pc == $past(pc) + `PC_ONE)
      else $error("taken skip kept the prefetched word");

   AST_LOW_PAGE: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      low_byte_write |=> pc[`PC_W-1:`PAGE_LSB] == $past(ir_pc[`PC_W-1:`PAGE_LSB])
                         && pc[7:0] == $past(res.result) && !ir_valid && !DM_WE)
      else $error("low byte write left the page or skipped the dummy");

   AST_PUSH: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      push |=> stack[$past(top)] == $past(pc) && top == $past(top) + 2'h1)
      else $error("push did not save the counter");

   AST_POP: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      do_return |=> pc == $past(pop_pc) && top == $past(top) - 2'h1)
      else $error("return did not restore the counter");

   AST_STACK_RESET: assert property (
      @(posedge CORE_CLK)
      !RST_N |=> return_stack_level_pointer == 3'h0 && top == 2'h0)
      else $error("stack not empty after reset");

   AST_FULL_HOLD: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      int_pend && full |=> !INT_ACK && (int_pend || INT_EVENT))
      else $error("interrupt acknowledged on a full stack");

   AST_FULL_CALL: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      call && full |=> pc == $past(ir[`PC_W-1:0]) && return_stack_level_pointer == `STACK_FULL)
      else $error("call on full stack was blocked");

   AST_TABLE_TWO: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      tbl_go |=> (tbl_busy && !commit) [*4] ##1 (!tbl_busy && DM_WE && DM_ADDR == $past(maddr, 5)))
      else $error("table read not two cycles");

   AST_RESET_PC: assert property (
      @(posedge CORE_CLK)
      !RST_N |=> pc == `RESET_VECTOR && PM_ADDR == `RESET_VECTOR && !ir_valid)
      else $error("reset did not clear pipeline to vector");

endmodule

// ===== tb/mem_model.sv
// Program and data memory seen by the core, both answering at once.
// Assumes the bench loads words straight into the arrays, data cells before reset and program words just after.
`timescale 1ns/100ps
`include "core_cfg.svh"
module mem_model (
   input  wire logic              clk,
   input  wire logic [`PC_W-1:0]  pm_addr,
   output logic [`PM_W-1:0]       pm_data,
   input  wire logic [`DM_AW-1:0] dm_addr,
   output logic [7:0]             dm_rdata,
   input  wire logic [7:0]        dm_wdata,
   input  wire logic              dm_we
);
   logic [`PM_W-1:0] pm [0:2047];
   logic [7:0]       dm [0:127];
   // Fetch is addressed purely by the presented word address
   assign pm_data = pm[pm_addr];
   assign dm_rdata = dm[dm_addr];
   // Plain always so the bench may also preset cells
   always @(posedge clk) begin
      if (dm_we)
         dm[dm_addr] <= dm_wdata;
   end
endmodule

// ===== tb/fetch_exec_core_tb_top.sv
// Self-checking bench of the fetch/execute core, one task per scenario.
// Assumes the memory model beside it and programs loaded just after reset.
`timescale 1ns/100ps
`include "core_cfg.svh"
module fetch_exec_core_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, int_event = 1'b0, int_enable = 1'b0, dm_we, int_ack, int_return;
   logic [10:0] pm_addr, int_vector = 11'h000;
   logic [14:0] pm_data;
   logic [6:0] dm_addr;
   logic [7:0] dm_rdata, dm_wdata, tp = 8'h00, table_high, acc;
   logic [3:0] ph;
   core_pkg::status_t status;
   int err_total = 0, n_compared = 0;
   fetch_exec_core fetch_exec_core_inst (.CORE_CLK(clk), .RST_N(rst_n), .PM_ADDR(pm_addr),
      .PM_DATA(pm_data), .DM_ADDR(dm_addr), .DM_RDATA(dm_rdata), .DM_WDATA(dm_wdata),
      .DM_WE(dm_we), .TABLE_POINTER(tp), .TABLE_HIGH(table_high), .INT_EVENT(int_event),
      .INT_ENABLE(int_enable), .INT_VECTOR(int_vector), .INT_ACK(int_ack), .INT_RETURN(int_return),
      .INSTRUCTION_PHASE_CLOCKS(ph), .STATUS(status), .ACC(acc));
   mem_model mem_model_inst (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
      .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we));
   // 20 MHz core clock
   initial begin
      forever #25 clk = ~clk;
   end
   //------------------------------------------------------------
   // Shared helpers
   //------------------------------------------------------------
   function automatic logic [14:0] wj(input logic [3:0] op, input logic [10:0] t);
      return {op, t};
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Clears program memory then holds reset two clocks; leaves us in phase one
   task automatic boot;
      foreach (mem_model_inst.pm[i]) mem_model_inst.pm[i] = 15'h0000;
      // A mid-run reset starts on a clock edge like the interrupt event
      if (rst_n) begin
         @(posedge clk);
         rst_n <= 1'b0;
      end
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
   endtask
   // One entry per instruction cycle; the fetch address is judged in phase one
   task automatic walk(input logic [10:0] e[$]);
      int k;
      foreach (e[i]) begin
         k = 0;
         while (ph !== 4'h1 && k < 8) begin
            @(posedge clk);
            #1;
            k++;
         end
         chk("fetch address", 16'(pm_addr), 16'(e[i]));
         @(posedge clk);
         #1;
      end
   endtask
   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic t_reset;
      boot();
      chk("phase", 16'(ph), 16'h1);
      chk("reset fetch", 16'(pm_addr), 16'h0);
      chk("acc", 16'(acc), 16'h0);
      for (int i = 1; i < 5; i++) begin
         @(posedge clk);
         #1;
         chk("phase", 16'(ph), 16'(1 << (i % 4)));
      end
      $display("test reset done");
   endtask
   // Move, add with half carry and overflow, xor written back to memory
   task automatic t_alu;
      mem_model_inst.dm[7'h10] = 8'h35;
      mem_model_inst.dm[7'h11] = 8'h4c;
      boot();
      mem_model_inst.pm[0] = wj(core_pkg::OP_ALU_A, {core_pkg::FN_MOVE, 7'h10});
      mem_model_inst.pm[1] = wj(core_pkg::OP_ALU_A, {core_pkg::FN_ADD, 7'h11});
      mem_model_inst.pm[2] = wj(core_pkg::OP_ALU_M, {core_pkg::FN_XOR, 7'h11});
      mem_model_inst.pm[3] = wj(core_pkg::OP_ALU_A, {core_pkg::FN_SUB, 7'h11});
      mem_model_inst.pm[4] = wj(core_pkg::OP_ALU_A, {core_pkg::FN_DECIMAL_ADJUST, 7'h11});
      walk('{11'h0, 11'h1, 11'h2, 11'h3});
      chk("acc", 16'(acc), 16'h81);
      chk("status", 16'(status), 16'ha);
      // 81 minus cd borrows to b4; adjusting b4 gives 14 with carry set
      walk('{11'h4, 11'h5, 11'h6});
      chk("acc after adjust", 16'(acc), 16'h14);
      chk("status after adjust", 16'(status), 16'h1);
      chk("xor result", 16'(mem_model_inst.dm[7'h11]), 16'hcd);
      $display("test alu done");
   endtask
   // Jump, taken skip and low-byte write; flushed words would jump far away
   task automatic t_flow;
      mem_model_inst.dm[7'h12] = 8'h01;
      mem_model_inst.dm[7'h13] = 8'h50;
      mem_model_inst.dm[7'h06] = 8'h77;
      boot();
      mem_model_inst.pm[0] = wj(core_pkg::OP_JUMP, 11'h020);
      mem_model_inst.pm[1] = wj(core_pkg::OP_JUMP, 11'h7ff);
      mem_model_inst.pm[11'h20] = wj(core_pkg::OP_SKZ, {core_pkg::FN_DEC, 7'h12});
      mem_model_inst.pm[11'h21] = wj(core_pkg::OP_JUMP, 11'h7ff);
      mem_model_inst.pm[11'h22] = wj(core_pkg::OP_ALU_A, {core_pkg::FN_MOVE, 7'h13});
      mem_model_inst.pm[11'h23] = wj(core_pkg::OP_ALU_M, {core_pkg::FN_MOVE, 7'h06});
      mem_model_inst.pm[11'h24] = wj(core_pkg::OP_JUMP, 11'h7ff);
      // Reading the low byte cell gives the instruction address, not 77
      mem_model_inst.pm[11'h50] = wj(core_pkg::OP_ALU_A, {core_pkg::FN_ADD, 7'h06});
      walk('{11'h0, 11'h1, 11'h20, 11'h21, 11'h22, 11'h23, 11'h24, 11'h50, 11'h51, 11'h52});
      chk("low byte read", 16'(acc), 16'ha0);
      chk("skip operand", 16'(mem_model_inst.dm[7'h12]), 16'h0);
      chk("low byte cell", 16'(mem_model_inst.dm[7'h06]), 16'h77);
      $display("test flow done");
   endtask
   // Last-page then current-page table read, two cycles each
   task automatic t_table;
      tp <= 8'h05;
      boot();
      mem_model_inst.pm[0] = wj(core_pkg::OP_TBL_LAST, 11'h014);
      mem_model_inst.pm[2] = wj(core_pkg::OP_TBL_CUR, 11'h015);
      mem_model_inst.pm[11'h705] = 15'h1a3c;
      mem_model_inst.pm[11'h005] = 15'h0b2d;
      walk('{11'h0, 11'h1, 11'h705, 11'h2, 11'h3, 11'h005, 11'h4});
      chk("table high", 16'(table_high), 16'h0b);
      chk("last page low", 16'(mem_model_inst.dm[7'h14]), 16'h3c);
      chk("page low", 16'(mem_model_inst.dm[7'h15]), 16'h2d);
      $display("test table done");
   endtask
   // Four nested calls fill the stack; the request must wait for a return
   task automatic t_int;
      logic seen;
      int k;
      seen = 1'b0;
      int_vector <= 11'h100;
      int_enable <= 1'b1;
      boot();
      mem_model_inst.pm[0] = wj(core_pkg::OP_CALL, 11'h010);
      mem_model_inst.pm[11'h10] = wj(core_pkg::OP_CALL, 11'h020);
      mem_model_inst.pm[11'h20] = wj(core_pkg::OP_CALL, 11'h030);
      mem_model_inst.pm[11'h30] = wj(core_pkg::OP_CALL, 11'h040);
      mem_model_inst.pm[11'h48] = wj(core_pkg::OP_RETURN_SUB, 11'h000);
      mem_model_inst.pm[11'h100] = wj(core_pkg::OP_RETURN_INT, 11'h000);
      for (k = 0; k < 200 && pm_addr !== 11'h041; k++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      int_event <= 1'b1;
      @(posedge clk);
      int_event <= 1'b0;
      for (k = 0; k < 200 && int_ack !== 1'b1; k++) begin
         @(posedge clk);
         #1;
         if (pm_addr === 11'h031)
            seen = 1'b1;
      end
      chk("ack seen", 16'(int_ack), 16'h1);
      chk("ack after return", 16'(seen), 16'h1);
      @(posedge clk);
      #1;
      chk("ack pulse", 16'(int_ack), 16'h0);
      for (k = 0; k < 40 && int_return !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk("interrupt return", 16'(int_return), 16'h1);
      int_enable <= 1'b0;
      $display("test interrupt done");
   endtask
   // Watchdog well beyond the few hundred clocks the tests need
   initial begin
      #250000;
      err_total++;
      conclude();
   end
   initial begin
      t_reset();
      t_alu();
      t_flow();
      t_table();
      t_int();
      conclude();
   end
endmodule
